// File: verilog/fslc_lock_ctrl.sv
// Notes on behaviour
// - Lock byte lives at address FFFFh, written by byte or burst write.
// - New lock byte takes effect only after reset; sampled on the third clock after reset ends.
// - FFh/00h unlocked, F5h upper lock, 05h gated lock, else hard lock.
// - Only whole-array erase removes lock, restoring FFh and erasing all blocks.
// - Lock field reports 00 unlocked, 11 hard, 01 upper, 10 gated.
// - Upper lock refuses commands on upper block, allows lower block.
// - Gated lock fully locks upper block; upper code may change lower block.
// - Gated self-programming commands from upper code need external select 1, lower block.
// - In host mode gated lock refuses everything like hard lock.
// - Under hard/upper lock, reads from unlocked code cannot reach locked memory.
// - Strobes driven high during reset.
// - Reset restores registers; internal RAM kept.
// - Reset writes ones to all port latches.
// - Power-down bit stops core clocks; only hardware reset exits.
// - Power-down keeps state and drives both strobes low.
// - Clock-stopped standby keeps all state and resumes next clock.
// - Full or block lock refuses erase, write, burst, verify on locked blocks.
//
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "fslc_regs.svh"
module fslc_lock_ctrl (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Lock byte as stored at the top program address
	input wire logic [7:0] sec_byte_i,
	// Pins, synchronised here
	input wire logic external_access_select_n_i,
	input wire logic host_mode_i,
	// Code table read check
	input wire logic code_table_read_i,
	input wire logic read_from_locked_i,
	input wire logic read_target_locked_i,
	output logic code_table_read_grant_o,
	// Flash controller side
	output logic flash_cmd_valid_o,
	output logic [2:0] flash_cmd_op_o,
	output logic flash_cmd_blk_o,
	output logic flash_cmd_burst_o,
	input wire logic flash_busy_i,
	input wire logic code_from_upper_i,
	// Chip pins and core clock gate
	output logic addr_latch_strobe_o,
	output logic program_store_strobe_n_o,
	output logic [7:0] port_latch_o,
	output logic core_clk_en_o
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0] sec;
		logic [1:0] lock;
		logic init_done;
		logic [3:0] rst_cnt;
		logic [2:0] ea_sync;
		logic ea_stable;
		logic [2:0] host_sync;
		logic host_stable;
		logic pd;
		logic cmd_valid;
		logic [2:0] cmd_op;
		logic cmd_blk;
		logic cmd_burst;
		logic refused;
		logic granted;
		logic wiped;
		logic [7:0] ports;
		logic [31:0] rdata;
		logic rvalid;
	} fslc_state_s;

	fslc_state_s st_q;
	fslc_state_s st_d;
	logic [1:0] lock_dec;
	logic grant;
	logic [2:0] wr_op;
	logic wr_blk;
	logic wr_burst;
	logic wr_cmd;

	// ==========================================================
	// Lock byte decode
	always_comb begin
		case (st_q.sec)
			`FSLC_SEC_ERASED, `FSLC_SEC_ZERO: lock_dec = fslc_pkg::FSLC_UNLOCKED;
			`FSLC_SEC_UPPER: lock_dec = fslc_pkg::FSLC_UPPER;
			`FSLC_SEC_GATED: lock_dec = fslc_pkg::FSLC_GATED;
			default: lock_dec = fslc_pkg::FSLC_HARD;
		endcase
	end

	// Command field extraction
	assign wr_cmd = avs_write_i && avs_address_i == `FSLC_OFF_CMD && avs_byteenable_i[0];
	assign wr_op = avs_writedata_i[`FSLC_CMD_OP_LSB +: 3];
	assign wr_blk = avs_writedata_i[`FSLC_CMD_BLK_BIT];
	assign wr_burst = avs_writedata_i[`FSLC_CMD_BURST_BIT];

	// ==========================================================
	// Grant decision, before any command reaches the array
	fslc_lock_judge u_judge (
		.lock_i(st_q.lock),
		.op_i(wr_op),
		.blk_i(wr_blk),
		.host_i(avs_writedata_i[`FSLC_CMD_HOST_BIT] | st_q.host_stable),
		.ext_sel_n_i(st_q.ea_stable),
		.from_upper_i(code_from_upper_i),
		.grant_o(grant)
	);

	// ==========================================================
	// Next state
	always_comb begin
		st_d = st_q;
		st_d.cmd_valid = 1'b0;
		st_d.rvalid = 1'b0;
		// Pin synchronisers: change once stages two and three agree
		st_d.ea_sync = {st_q.ea_sync[1:0], external_access_select_n_i};
		st_d.host_sync = {st_q.host_sync[1:0], host_mode_i};
		if (st_q.ea_sync[2] == st_q.ea_sync[1]) begin
			st_d.ea_stable = st_q.ea_sync[2];
		end
		if (st_q.host_sync[2] == st_q.host_sync[1]) begin
			st_d.host_stable = st_q.host_sync[2];
		end
		// Post-reset capture of the lock byte
		if (!st_q.init_done) begin
			if (st_q.rst_cnt != `FSLC_RST_CYC) begin
				st_d.rst_cnt = st_q.rst_cnt + 4'd1;
			end else begin
				st_d.sec = sec_byte_i;
				st_d.init_done = 1'b1;
			end
		end else begin
			st_d.lock = lock_dec;
		end
		// Command mailbox write, accepted one cycle, judged at once
		// A command still pending towards the array counts as busy
		if (wr_cmd && st_q.init_done && !st_q.pd && !flash_busy_i && !st_q.cmd_valid) begin
			if (grant && wr_op != fslc_pkg::FSLC_OP_NONE) begin
				st_d.cmd_valid = 1'b1;
				st_d.cmd_op = wr_op;
				st_d.cmd_blk = wr_blk;
				st_d.cmd_burst = wr_burst;
				st_d.granted = 1'b1;
				if (wr_op == fslc_pkg::FSLC_OP_CHIP_ERASE) begin
					st_d.wiped = 1'b1;
				end
			end else if (wr_op != fslc_pkg::FSLC_OP_NONE) begin
				st_d.refused = 1'b1;
			end
		end
		// Power-down request; only reset leaves it
		if (avs_write_i && avs_address_i == `FSLC_OFF_PWR && avs_byteenable_i[0]
			&& avs_writedata_i[`FSLC_PWR_PD_BIT]) begin
			st_d.pd = 1'b1;
		end
		// Status flags clear on write of one
		if (avs_write_i && avs_address_i == `FSLC_OFF_STAT && avs_byteenable_i[0]) begin
			if (avs_writedata_i[0]) begin
				st_d.refused = 1'b0;
			end
			if (avs_writedata_i[1]) begin
				st_d.granted = 1'b0;
			end
		end
		// A new event wins over a clear in the same cycle
		if (wr_cmd && st_q.init_done && !st_q.pd && !flash_busy_i && !st_q.cmd_valid
			&& wr_op != 3'b000) begin
			if (grant) begin
				st_d.granted = 1'b1;
			end else begin
				st_d.refused = 1'b1;
			end
		end
		// Read data
		if (avs_read_i && !st_q.rvalid) begin
			st_d.rvalid = 1'b1;
			case (avs_address_i)
				`FSLC_OFF_CFG: st_d.rdata = {25'h0, st_q.lock, 5'h0};
				`FSLC_OFF_CMD: st_d.rdata = {25'h0, st_q.cmd_burst, 1'b0, st_q.cmd_blk,
					1'b0, st_q.cmd_op};
				`FSLC_OFF_STAT: st_d.rdata = {29'h0, flash_busy_i,
					st_q.granted, st_q.refused};
				`FSLC_OFF_PWR: st_d.rdata = {30'h0, st_q.pd, 1'b0};
				default: st_d.rdata = 32'h0;
			endcase
		end
	end

	// ==========================================================
	// Registers; reset restores all to constants, RAM lives elsewhere
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_q <= '0;
			st_q.sec <= `FSLC_SEC_ERASED;
			st_q.lock <= fslc_pkg::FSLC_UNLOCKED;
			st_q.ea_sync <= 3'h7;
			st_q.ea_stable <= 1'b1;
			st_q.ports <= `FSLC_PORT_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// Outputs
	assign avs_readdata_o = st_q.rdata;
	assign avs_waitrequest_o = avs_read_i & ~st_q.rvalid;
	assign flash_cmd_valid_o = st_q.cmd_valid;
	assign flash_cmd_op_o = st_q.cmd_op;
	assign flash_cmd_blk_o = st_q.cmd_blk;
	assign flash_cmd_burst_o = st_q.cmd_burst;
	assign port_latch_o = st_q.ports;
	assign core_clk_en_o = ~st_q.pd;

	// Strobes high in reset, low in power-down
	assign addr_latch_strobe_o = ~reset_n_i | ~st_q.pd;
	assign program_store_strobe_n_o = ~reset_n_i | ~st_q.pd;

	// Code table read gate
	always_comb begin
		code_table_read_grant_o = 1'b1;
		if (code_table_read_i && (st_q.lock == fslc_pkg::FSLC_HARD
			|| st_q.lock == fslc_pkg::FSLC_UPPER)) begin
			code_table_read_grant_o = read_from_locked_i | ~read_target_locked_i;
		end
	end
endmodule // fslc_lock_ctrl
`default_nettype wire

// File: inc/fslc_regs.svh
`ifndef FSLC_REGS_SVH
`define FSLC_REGS_SVH
// ==========================================================
// Register offsets (byte addresses, one word each)
`define FSLC_OFF_CFG 4'h0
`define FSLC_OFF_CMD 4'h4
`define FSLC_OFF_STAT 4'h8
`define FSLC_OFF_PWR 4'hc
// ==========================================================
// Lock byte encodings
`define FSLC_SEC_ERASED 8'hff
`define FSLC_SEC_ZERO 8'h00
`define FSLC_SEC_UPPER 8'hf5
`define FSLC_SEC_GATED 8'h05
// ==========================================================
// Field positions
`define FSLC_CFG_LOCK_LSB 5
`define FSLC_CMD_OP_LSB 0
`define FSLC_CMD_BLK_BIT 4
`define FSLC_CMD_HOST_BIT 5
`define FSLC_CMD_BURST_BIT 6
`define FSLC_PWR_PD_BIT 1
// ==========================================================
// Reset values and timing
`define FSLC_PORT_RESET 8'hff
`define FSLC_RST_CYC 4'd2
`endif

// File: inc/fslc_pkg.sv
package fslc_pkg;
	// Decoded lock state, encoded as reported in the config field
	typedef enum logic [1:0] {
		FSLC_UNLOCKED = 2'b00,
		FSLC_UPPER = 2'b01,
		FSLC_GATED = 2'b10,
		FSLC_HARD = 2'b11
	} fslc_lock_e;
	// Flash operations
	typedef enum logic [2:0] {
		FSLC_OP_NONE = 3'b000,
		FSLC_OP_CHIP_ERASE = 3'b001,
		FSLC_OP_BLOCK_ERASE = 3'b010,
		FSLC_OP_SECTOR_ERASE = 3'b011,
		FSLC_OP_BYTE_WRITE = 3'b100,
		FSLC_OP_BYTE_VERIFY = 3'b101
	} fslc_op_e;
endpackage

// File: verilog/fslc_lock_judge.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Combinational grant decision for one flash command
module fslc_lock_judge (
	input wire logic [1:0] lock_i,
	input wire logic [2:0] op_i,
	input wire logic blk_i,
	input wire logic host_i,
	input wire logic ext_sel_n_i,
	input wire logic from_upper_i,
	output logic grant_o
);
	// Lock table evaluation
	always_comb begin
		grant_o = 1'b0;
		if (op_i == fslc_pkg::FSLC_OP_CHIP_ERASE) begin
			grant_o = 1'b1;
		end else if (op_i != fslc_pkg::FSLC_OP_NONE) begin
			case (lock_i)
				fslc_pkg::FSLC_UNLOCKED: grant_o = 1'b1;
				fslc_pkg::FSLC_UPPER: grant_o = ~blk_i;
				fslc_pkg::FSLC_GATED: begin
					grant_o = ~host_i & ~blk_i & ext_sel_n_i & from_upper_i;
				end
				default: grant_o = 1'b0;
			endcase
		end
	end
endmodule // fslc_lock_judge
`default_nettype wire

// File: verification/fslc_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Flash array stand-in, busy for a while after each granted command
module fslc_flash_model #(
	parameter int BUSY_CYC = 3
) (
	input wire logic clk_i,
	input wire logic cmd_valid_i,
	input wire logic [2:0] cmd_op_i,
	output logic busy_o,
	output logic [7:0] sec_byte_o
);
	int left = 0;
	int n_done = 0;
	logic [7:0] sec_q = 8'hff;
	assign busy_o = left > 0;
	assign sec_byte_o = sec_q;
	// Only a granted command reaches the array
	always @(posedge clk_i) begin
		if (cmd_valid_i) begin
			n_done <= n_done + 1;
			left <= BUSY_CYC;
			if (cmd_op_i == 3'h1) sec_q <= 8'hff;
		end else if (left > 0) begin
			left <= left - 1;
		end
	end
endmodule // fslc_flash_model
`default_nettype wire

// File: verification/fslc_lock_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checks
module fslc_lock_monitor (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic avs_waitrequest_o,
	input wire logic flash_cmd_valid_o,
	input wire logic flash_busy_i,
	input wire logic addr_latch_strobe_o,
	input wire logic program_store_strobe_n_o,
	input wire logic core_clk_en_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Read handshake steps
	sequence rd_wait_s; avs_read_i && avs_waitrequest_o; endsequence
	sequence rd_ans_s; avs_read_i && !avs_waitrequest_o; endsequence
	read_first_wait_a: assert property ($rose(avs_read_i) |-> rd_wait_s)
		else $error("read not held off");
	read_answer_a: assert property (rd_wait_s |=> rd_ans_s) else $error("read answer late");
	write_no_wait_a: assert property (avs_write_i |-> !avs_waitrequest_o) else $error("write held");
	cmd_pulse_a: assert property (flash_cmd_valid_o |=> !flash_cmd_valid_o) else $error("long pulse");
	cmd_cause_a: assert property (flash_cmd_valid_o |-> $past(avs_write_i && !flash_busy_i))
		else $error("command without idle write");
	pd_entry_a: assert property (avs_write_i && avs_address_i == 4'hc && avs_writedata_i[1]
		&& avs_byteenable_i[0] |-> ##[1:2] !core_clk_en_o) else $error("no power down");
	pd_hold_a: assert property (!core_clk_en_o |=> !core_clk_en_o) else $error("left power down");
	pd_strobe_a: assert property (!core_clk_en_o |-> !addr_latch_strobe_o
		&& !program_store_strobe_n_o) else $error("strobes high in power down");
endmodule // fslc_lock_monitor
bind fslc_lock_ctrl fslc_lock_monitor mon (.ref_clk_i, .reset_n_i, .avs_address_i, .avs_read_i,
	.avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_waitrequest_o, .flash_cmd_valid_o,
	.flash_busy_i, .addr_latch_strobe_o, .program_store_strobe_n_o, .core_clk_en_o);
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench top
module tb_top;
	logic ref_clk_i, reset_n_i, avs_read_i, avs_write_i, avs_waitrequest_o, host_mode_i;
	logic [3:0] avs_address_i, avs_byteenable_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, d;
	logic [7:0] sec_byte_i, port_latch_o;
	logic external_access_select_n_i, code_table_read_i, read_from_locked_i;
	logic read_target_locked_i, code_table_read_grant_o, flash_cmd_valid_o, flash_cmd_blk_o;
	logic [2:0] flash_cmd_op_o;
	logic flash_cmd_burst_o, flash_busy_i, code_from_upper_i, addr_latch_strobe_o;
	logic program_store_strobe_n_o, core_clk_en_o;
	logic [7:0] sb_tab [6] = '{8'hff, 8'h00, 8'hf5, 8'h05, 8'h55, 8'ha3};
	logic [1:0] lk_tab [6] = '{2'b00, 2'b00, 2'b01, 2'b10, 2'b11, 2'b11};
	int fails = 0;
	int n_compared = 0;
	fslc_lock_ctrl uut (.*);
	fslc_flash_model #(.BUSY_CYC(3)) fm (.clk_i(ref_clk_i), .cmd_valid_i(flash_cmd_valid_o),
		.cmd_op_i(flash_cmd_op_o), .busy_o(flash_busy_i), .sec_byte_o(sec_byte_i));
	// Clock, free-running, never gated in mid-period
	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// One bus cycle, held until waitrequest is seen low
	task automatic bus(input logic [3:0] a, input logic wr, input logic [7:0] wd);
		int n;
		avs_address_i <= a;
		avs_writedata_i <= {24'h0, wd};
		avs_byteenable_i <= 4'h1;
		if (wr) avs_write_i <= 1'b1;
		else avs_read_i <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge ref_clk_i);
			if (avs_waitrequest_o === 1'b0) begin
				d = avs_readdata_o;
				break;
			end
		end
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		chk("bus wait", n < 20, 1'b1);
		if (n == 20) complete_run();
		@(posedge ref_clk_i);
	endtask
	// Command write, then count what reached the array
	task automatic cmd(input logic [2:0] op, input logic blk, host, exp, input string what);
		int n0, k;
		n0 = fm.n_done;
		bus(4'h4, 1'b1, {2'b00, host, blk, 1'b0, op});
		@(posedge ref_clk_i);
		for (k = 0; k < 50 && flash_busy_i !== 1'b0; k++) @(posedge ref_clk_i);
		chk(what, fm.n_done - n0, {31'h0, exp});
		if (k == 50) complete_run();
		if (exp) chk("command op", flash_cmd_op_o, {29'h0, op});
		bus(4'h8, 1'b0, 8'h00);
		chk("granted flag", d[1], exp);
		bus(4'h8, 1'b1, 8'h03);
	endtask
	task automatic rst(input logic [7:0] sb);
		fm.sec_q = sb;
		reset_n_i <= 1'b0;
		repeat (12) @(posedge ref_clk_i);
		chk("strobes in reset", {addr_latch_strobe_o, program_store_strobe_n_o}, 2'b11);
		reset_n_i <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		chk("port latches", port_latch_o, 8'hff);
		chk("clock enable", core_clk_en_o, 1'b1);
	endtask
	// Main sequence
	initial begin
		{reset_n_i, avs_read_i, avs_write_i, host_mode_i, read_from_locked_i} = '0;
		{avs_address_i, avs_byteenable_i, avs_writedata_i, read_target_locked_i} = '0;
		{external_access_select_n_i, code_table_read_i, code_from_upper_i} = 3'b111;
		for (int i = 0; i < 6; i++) begin
			rst(sb_tab[i]);
			bus(4'h0, 1'b0, 8'h00);
			chk("lock field", d[6:5], lk_tab[i]);
			cmd(3'(2 + i % 4), 1'b1, 1'b0, lk_tab[i] == 2'b00, "upper cmd");
			cmd(3'(5 - i % 4), 1'b0, 1'b0, lk_tab[i] != 2'b11, "lower cmd");
			cmd(3'h4, 1'b0, 1'b1, lk_tab[i][1] == 1'b0, "host cmd");
			if (i == 3) begin
				external_access_select_n_i <= 1'b0;
				repeat (4) @(posedge ref_clk_i);
				cmd(3'h4, 1'b0, 1'b0, 1'b0, "gated ext low");
				external_access_select_n_i <= 1'b1;
				repeat (4) @(posedge ref_clk_i);
			end
			if (i == 4) begin
				read_target_locked_i <= 1'b1;
				@(negedge ref_clk_i);
				chk("table read", code_table_read_grant_o, 1'b0);
				@(posedge ref_clk_i);
				read_from_locked_i <= 1'b1;
				@(negedge ref_clk_i);
				chk("table read", code_table_read_grant_o, 1'b1);
				@(posedge ref_clk_i);
				{read_from_locked_i, read_target_locked_i} <= 2'b00;
			end
		end
		cmd(3'h1, 1'b0, 1'b0, 1'b1, "chip erase");
		chk("erased byte", sec_byte_i, 8'hff);
		rst(fm.sec_q);
		fm.sec_q = 8'h55;
		bus(4'h0, 1'b0, 8'h00);
		chk("lock field", d[6:5], 2'b00);
		cmd(3'h4, 1'b1, 1'b0, 1'b1, "upper cmd");
		bus(4'hc, 1'b1, 8'h02);
		chk("power down", {core_clk_en_o, addr_latch_strobe_o, program_store_strobe_n_o}, 3'b000);
		cmd(3'h4, 1'b0, 1'b0, 1'b0, "cmd in power down");
		rst(8'hff);
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
